//--- hexff_params.svh
`ifndef HEXFF_PARAMS_SVH
`define HEXFF_PARAMS_SVH
`define HEXFF_WIDTH     6
`define HEXFF_RESET_VAL 6'h00
`endif

//--- hexff_pkg.sv
`include "hexff_params.svh"
package hexff_pkg;
  typedef logic [`HEXFF_WIDTH-1:0] bank_t;
  typedef struct packed {
    bank_t flop_output;
    bank_t flop_output_n;
  } out_pair_s;
endpackage

//--- hex_dff_dual_clock_reset.sv
`timescale 1ns/100ps
`include "hexff_params.svh"
module hex_dff_dual_clock_reset (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  input  wire logic              clock_in_a,
  input  wire logic              clock_in_b,
  input  wire logic              master_clear,
  input  wire hexff_pkg::bank_t  flop_input,
  output hexff_pkg::out_pair_s   outs
);
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  // a pin change at edge k reaches sync_r at k+2 and an ored rise then
  // loads the slave at k+3; a clear forces the true outputs low from k+2.
  // clk_en low freezes every stage, so pin activity while disabled is
  // seen only if it is still present once the enable returns.

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2+`HEXFF_WIDTH:0] meta_r;
  logic [2+`HEXFF_WIDTH:0] sync_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (clk_en) begin
      meta_r <= {master_clear, clock_in_a, clock_in_b, flop_input};
      sync_r <= meta_r;
    end
  end
  logic             clr_s;
  logic             ca_s;
  logic             cb_s;
  hexff_pkg::bank_t d_s;
  assign {clr_s, ca_s, cb_s, d_s} = sync_r;

  // pins arrive with no relation to mclk; only sync_r feeds the logic below,
  // so a metastable meta_r bit never reaches the edge detector or the stages
  AST_SYNC_SHIFT: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en |=> sync_r == $past(meta_r))
    else $error("synchroniser did not advance");

  AST_SYNC_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    !clk_en |=> $stable(meta_r) && $stable(sync_r))
    else $error("synchroniser moved while disabled");

  // ----------------------------------------------------------------
  // ored clock and edge detect
  // ----------------------------------------------------------------
  logic ored_clk;
  logic ored_clk_r;
  logic ored_rise;
  assign ored_clk  = ca_s | cb_s;
  assign ored_rise = ored_clk & ~ored_clk_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ored_clk_r <= 1'b0;
    end else if (clk_en) begin
      ored_clk_r <= ored_clk;
    end
  end

  // a rise lasts one enabled cycle, so one pin edge loads the bank once
  AST_OR_CLK: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en |=> ored_clk_r == $past(ca_s || cb_s))
    else $error("or clock wrong");

  AST_RISE_ONCE: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && ored_rise |=> !ored_rise)
    else $error("ored rise lasted more than one cycle");

  AST_RISE_FROZEN: assert property (@(posedge mclk) disable iff (!rstn)
    !clk_en |=> $stable(ored_clk_r))
    else $error("edge detector moved while disabled");

  AST_RISE_FROM_A: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && ca_s && !cb_s && !ored_clk_r && !clr_s |=> slave_r == $past(master_r))
    else $error("first clock input alone did not load");

  AST_RISE_FROM_B: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && cb_s && !ca_s && !ored_clk_r && !clr_s |=> slave_r == $past(master_r))
    else $error("second clock input alone did not load");

  AST_HIGH_BOTH: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && ca_s && cb_s && ored_clk_r && !clr_s |=> $stable(slave_r))
    else $error("outputs moved with both clocks high");

  // ----------------------------------------------------------------
  // master stage: follows data while the ored clock is low
  // ----------------------------------------------------------------
  hexff_pkg::bank_t master_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      master_r <= `HEXFF_RESET_VAL;
    end else if (clk_en && !ored_clk) begin
      master_r <= d_s;
    end
  end

  // the master is shut while the ored clock is high, so data that changes
  // after the edge cannot slip through to the slave on the same pulse
  AST_MASTER: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && !ored_clk |=> master_r == $past(d_s))
    else $error("master not following input");

  AST_MASTER_SHUT: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && ored_clk |=> $stable(master_r))
    else $error("master moved while clock high");

  AST_MASTER_FROZEN: assert property (@(posedge mclk) disable iff (!rstn)
    !clk_en |=> $stable(master_r))
    else $error("master moved while disabled");

  // ----------------------------------------------------------------
  // slave stage, one element per bit
  // ----------------------------------------------------------------
  hexff_pkg::bank_t slave_r;
  genvar gi;
  generate
    for (gi = 0; gi < `HEXFF_WIDTH; gi++) begin : g_elem
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          slave_r[gi] <= 1'b0;
        end else if (clk_en) begin
          if (clr_s) begin
            slave_r[gi] <= 1'b0;
          end else if (ored_rise) begin
            slave_r[gi] <= master_r[gi];
          end
        end
      end
      // each bit checked alone so a crossed wire between elements shows up
      AST_BIT_LOAD: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && ored_rise && !clr_s |=> slave_r[gi] == $past(master_r[gi]))
        else $error("element did not load its own input");

      AST_BIT_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
        clk_en && clr_s |=> !slave_r[gi])
        else $error("element not cleared");

      AST_BIT_FROZEN: assert property (@(posedge mclk) disable iff (!rstn)
        !clk_en |=> $stable(slave_r[gi]))
        else $error("element moved while disabled");

      AST_BIT_PAIR: assert property (@(posedge mclk) disable iff (!rstn)
        outs.flop_output_n[gi] != outs.flop_output[gi])
        else $error("element outputs not complementary");
    end
  endgenerate

  // ----------------------------------------------------------------
  // slave checks
  // ----------------------------------------------------------------
  AST_LOAD: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && ored_rise && !clr_s |=> slave_r == $past(master_r))
    else $error("edge did not load data");

  AST_HOLD_LOW: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && !ca_s && !cb_s && !clr_s |=> $stable(slave_r))
    else $error("outputs moved with both clocks low");

  AST_NO_SECOND: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && ored_clk_r && ored_clk && !clr_s |=> $stable(slave_r))
    else $error("outputs moved without ored rise");

  AST_ONLY_EDGE: assert property (@(posedge mclk) disable iff (!rstn)
    !(clk_en && (ored_rise || clr_s)) |=> $stable(slave_r))
    else $error("outputs moved without cause");

  AST_STAY_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && clr_s ##1 (clk_en && !clr_s && !ored_rise) |=> slave_r == 6'h00)
    else $error("output left clear without edge");

  AST_CLEAR_WINS: assert property (@(posedge mclk) disable iff (!rstn)
    clk_en && clr_s && ored_rise |=> slave_r == 6'h00)
    else $error("edge beat a simultaneous clear");

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // clear bypasses the slave so it acts without waiting for an edge
  hexff_pkg::bank_t q_live;
  assign q_live = clr_s ? `HEXFF_RESET_VAL : slave_r;
  // one assignment for the whole pair keeps the output a single driver
  assign outs = hexff_pkg::out_pair_s'{flop_output:   q_live,
                                       flop_output_n: ~q_live};

  AST_COMPLEMENT: assert property (@(posedge mclk) disable iff (!rstn)
    outs.flop_output_n == ~outs.flop_output)
    else $error("complement mismatch");

  AST_CLEAR_LOW: assert property (@(posedge mclk) disable iff (!rstn)
    clr_s |-> outs.flop_output == 6'h00)
    else $error("clear did not force low");

  AST_OUT_SLAVE: assert property (@(posedge mclk) disable iff (!rstn)
    !clr_s |-> outs.flop_output == slave_r)
    else $error("true outputs differ from stored bits");

  AST_OUT_N_SLAVE: assert property (@(posedge mclk) disable iff (!rstn)
    !clr_s |-> outs.flop_output_n == ~slave_r)
    else $error("complement outputs differ from stored bits");

  // ----------------------------------------------------------------
  // clear tracking for checks
  // ----------------------------------------------------------------
  // set by a clear, dropped by the first enabled edge that loads data
  logic held_clear_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      held_clear_r <= 1'b1;
    end else if (clk_en) begin
      if (clr_s) begin
        held_clear_r <= 1'b1;
      end else if (ored_rise) begin
        held_clear_r <= 1'b0;
      end
    end
  end

  AST_HELD_CLEAR: assert property (@(posedge mclk) disable iff (!rstn)
    held_clear_r |-> slave_r == `HEXFF_RESET_VAL)
    else $error("bank left the cleared state without a load");

endmodule // hex_dff_dual_clock_reset

//--- flop_source.sv
`timescale 1ns/100ps
module flop_source (
  input  wire logic        mclk,
  output logic             clock_in_a,
  output logic             clock_in_b,
  output logic             master_clear,
  output hexff_pkg::bank_t flop_input
);
  initial {clock_in_a, clock_in_b, master_clear, flop_input} = '0;
  // one change per call, then settle past the sync and load path
  task automatic drive(input logic a, input logic b, input logic clr,
                       input hexff_pkg::bank_t d);
    @(posedge mclk);
    clock_in_a   <= a;
    clock_in_b   <= b;
    master_clear <= clr;
    flop_input   <= d;
    repeat (5) @(posedge mclk);
  endtask
endmodule // flop_source

//--- hex_dff_dual_clock_reset_tb_top.sv
`timescale 1ns/100ps
module hex_dff_dual_clock_reset_tb_top;
  logic                 mclk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 en   = 1'b1;
  logic                 ca, cb, clr;
  hexff_pkg::bank_t     d;
  hexff_pkg::out_pair_s outs;
  int                   err_total = 0;
  int                   n_compared = 0;
  int                   cyc = 0;
  always #25 mclk = ~mclk;
  flop_source i_src (.mclk(mclk), .clock_in_a(ca), .clock_in_b(cb), .master_clear(clr),
                     .flop_input(d));
  hex_dff_dual_clock_reset i_dut (.mclk(mclk), .rstn(rstn), .clk_en(en), .clock_in_a(ca),
    .clock_in_b(cb), .master_clear(clr), .flop_input(d), .outs(outs));
  task automatic summarize();
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input hexff_pkg::bank_t exp);
    n_compared++;
    if (outs !== {exp, ~exp}) begin
      err_total++;
      $display("MISMATCH outs exp %h seen %h", {exp, ~exp}, outs);
    end
  endtask
  task automatic test_load();
    i_src.drive(1'b0, 1'b0, 1'b0, 6'h2D);
    chk(6'h00);
    i_src.drive(1'b1, 1'b0, 1'b0, 6'h2D);
    chk(6'h2D);
  endtask
  task automatic test_blocked();
    i_src.drive(1'b1, 1'b0, 1'b0, 6'h15);
    i_src.drive(1'b1, 1'b1, 1'b0, 6'h15);
    chk(6'h2D);
    i_src.drive(1'b0, 1'b0, 1'b0, 6'h15);
    chk(6'h2D);
    i_src.drive(1'b0, 1'b1, 1'b0, 6'h15);
    chk(6'h15);
  endtask
  task automatic test_clear();
    i_src.drive(1'b0, 1'b1, 1'b1, 6'h3F);
    chk(6'h00);
    i_src.drive(1'b0, 1'b0, 1'b0, 6'h3F);
    chk(6'h00);
    i_src.drive(1'b1, 1'b0, 1'b0, 6'h3F);
    chk(6'h3F);
  endtask
  task automatic test_freeze();
    i_src.drive(1'b0, 1'b0, 1'b0, 6'h0C);
    chk(6'h3F);
    @(posedge mclk);
    en <= 1'b0;
    i_src.drive(1'b1, 1'b0, 1'b0, 6'h0C);
    chk(6'h3F);
    en <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(6'h0C);
  endtask
  task automatic test_clear_wins();
    i_src.drive(1'b0, 1'b0, 1'b0, 6'h2A);
    chk(6'h0C);
    i_src.drive(1'b1, 1'b0, 1'b1, 6'h2A);
    chk(6'h00);
    i_src.drive(1'b0, 1'b0, 1'b0, 6'h2A);
    chk(6'h00);
    i_src.drive(1'b1, 1'b0, 1'b0, 6'h2A);
    chk(6'h2A);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    test_load();
    test_blocked();
    test_clear();
    test_freeze();
    test_clear_wins();
    summarize();
  end
endmodule // hex_dff_dual_clock_reset_tb_top
